// ### sat16_ext_osc.sv
`timescale 1ns/10ps
module sat16_ext_osc
(
  input wire logic ref_clk,
  input wire logic run,
  input wire logic [7:0] half_cyc,
  output logic ext_clk
);
  logic [7:0] cnt;
  initial
  begin
    cnt = 8'h00;
    ext_clk = 1'b0;
  end
  // slow oscillator stand-in
  // Parks low between bursts so no stray edge is counted
  always @(posedge ref_clk)
  begin
    if (!run)
    begin
      cnt <= 8'h00;
      ext_clk <= 1'b0;
    end
    else if (cnt >= half_cyc - 8'h01)
    begin
      cnt <= 8'h00;
      ext_clk <= ~ext_clk;
    end
    else
      cnt <= cnt + 8'h01;
  end
endmodule

// ### sat16_pkg.sv
package sat16_pkg;

  // Register byte offsets
  localparam logic [15:0] CTRL_OFS = 16'h0600;
  localparam logic [15:0] COUNT_OFS = 16'h0610;
  localparam logic [15:0] PERIOD_OFS = 16'h0620;

  // Alias offsets added to a register base
  localparam logic [3:0] ALIAS_CLR_OFS = 4'h4;
  localparam logic [3:0] ALIAS_SET_OFS = 4'h8;
  localparam logic [3:0] ALIAS_INV_OFS = 4'hc;

  // Control field positions
  localparam int ON_BIT = 15;
  localparam int IDLE_STOP_BIT = 13;
  localparam int WR_BLOCK_BIT = 12;
  localparam int PENDING_BIT = 11;
  localparam int GATE_BIT = 7;
  localparam int PRESCALE_LSB = 4;
  localparam int SYNC_BIT = 2;
  localparam int SOURCE_BIT = 1;

  // Writable control bits; the pending bit is read-only
  localparam logic [15:0] CTRL_WR_MASK = 16'hb0b6;

  // Reset values
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] PERIOD_RESET = 16'hffff;

  // Prescaler terminal counts for 1, 8, 64 and 256
  localparam logic [7:0] PRESC_LIMIT_1 = 8'h00;
  localparam logic [7:0] PRESC_LIMIT_8 = 8'h07;
  localparam logic [7:0] PRESC_LIMIT_64 = 8'h3f;
  localparam logic [7:0] PRESC_LIMIT_256 = 8'hff;

  // Cycles an asynchronous count write stays pending
  localparam logic [1:0] ASYNC_WR_CYCLES = 2'h2;

  // Order follows address bits [3:2]
  typedef enum logic [1:0] {SAT16_WR_PLAIN, SAT16_WR_CLR, SAT16_WR_SET, SAT16_WR_INV} sat16_wr_t;

  function automatic logic [15:0] sat16_alias(sat16_wr_t kind, logic [15:0] old_v,
                                              logic [15:0] data);
    logic [15:0] res;
    res = data;
    unique case (kind)
      SAT16_WR_PLAIN: res = data;
      SAT16_WR_CLR: res = old_v & ~data;
      SAT16_WR_SET: res = old_v | data;
      SAT16_WR_INV: res = old_v ^ data;
    endcase
    return res;
  endfunction

endpackage

// ### sat16_presc.sv
`timescale 1ns/10ps
module sat16_presc
  import sat16_pkg::*;
#(
  parameter int CNT_W = 8
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic tick_in,
  input wire logic [1:0] prescale_select,
  output logic tick_out
);

  logic [CNT_W-1:0] div_cnt;
  logic [CNT_W-1:0] limit;

  generate
    if (CNT_W < 8)
    begin : g_check
      $error("sat16_presc: CNT_W must be at least 8");
    end
  endgenerate

  always_comb
  begin
    limit = CNT_W'(PRESC_LIMIT_1);
    unique case (prescale_select)
      2'h0: limit = CNT_W'(PRESC_LIMIT_1);
      2'h1: limit = CNT_W'(PRESC_LIMIT_8);
      2'h2: limit = CNT_W'(PRESC_LIMIT_64);
      2'h3: limit = CNT_W'(PRESC_LIMIT_256);
    endcase
  end

  assign tick_out = tick_in && (div_cnt == limit);

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      div_cnt <= '0;
    else if (clear || tick_out)
      div_cnt <= '0;
    else if (tick_in)
      div_cnt <= div_cnt + CNT_W'(1);
  end

  presc_div_limit_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tick_in && !clear && div_cnt != limit |=> div_cnt == $past(div_cnt) + CNT_W'(1))
    else $error("prescaler count did not step before its terminal count");

  presc_div8_gap_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tick_out && prescale_select == 2'h1 && !clear ##1 (prescale_select == 2'h1 && !clear)[*7]
    |-> !tick_out)
    else $error("divide by eight ticked early");

endmodule

// ### sat16_timer.sv
`timescale 1ns/10ps
// How it works
// - One 16-bit counter, synchronous or asynchronous.
// - Internal, gated internal, sync external, async external.
// - Counts in idle unless idle stop is set; in sleep only in async mode.
// - Async mode counts a slow secondary oscillator.
// - Aliases at +4/+8/+c clear, set, invert.
// - Reset: control and count zero, period ffff.
// - Prescale codes divide by 1, 8, 64, 256.
// - Source bit picks external pin or internal.
// - Write block ignores count writes while pending.
// - Gate counts only when internal clock selected.
module sat16_timer
  import sat16_pkg::*;
#(
  parameter int ADDR_W = 16
)
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  input wire logic external_count_input,
  input wire logic gate_in,
  input wire logic cpu_idle,
  input wire logic cpu_sleep,
  output logic timer_event
);

  generate
    if (ADDR_W < 12)
    begin : g_check
      $error("sat16_timer: ADDR_W too small for the register offsets");
    end
  endgenerate

  logic rst_meta;
  logic rst_n;
  logic [15:0] ctrl;
  logic [15:0] count;
  logic [15:0] period;
  logic pending;
  logic [1:0] pend_cnt;
  logic [15:0] pend_val;
  logic ext_meta;
  logic ext_sync;
  logic ext_sync_d;
  logic ext_prev;
  logic [15:0] base;
  logic addr_ok;
  sat16_wr_t kind;
  logic ctrl_wr;
  logic cnt_wr;
  logic per_wr;
  logic [15:0] next_cnt_wr;
  logic timer_on;
  logic async_mode;
  logic active;
  logic edge_sync;
  logic edge_async;
  logic raw_tick;
  logic tick;
  logic direct_wr;
  logic start_wr;
  logic apply_wr;
  logic blocked;
  logic [15:0] ctrl_view;

  // Reset release through two flops
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Cast keeps base 16 bits wide for any legal address width
  assign base = 16'({addr[ADDR_W-1:4], 4'h0});
  assign addr_ok = (addr[1:0] == 2'h0) && ((addr >> 16) == '0);
  assign kind = sat16_wr_t'(addr[3:2]);
  assign ctrl_wr = wr_en && addr_ok && base == CTRL_OFS;
  assign cnt_wr = wr_en && addr_ok && base == COUNT_OFS;
  assign per_wr = wr_en && addr_ok && base == PERIOD_OFS;
  assign next_cnt_wr = sat16_alias(kind, count, wr_data[15:0]);

  assign timer_on = ctrl[ON_BIT];
  assign async_mode = ctrl[SOURCE_BIT] && !ctrl[SYNC_BIT];
  assign active = timer_on && !(cpu_idle && ctrl[IDLE_STOP_BIT]) && (!cpu_sleep || async_mode);

  // External input synchroniser for the synchronous external mode
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      ext_sync_d <= 1'b0;
      ext_prev <= 1'b0;
    end
    else
    begin
      ext_meta <= external_count_input;
      ext_sync <= ext_meta;
      ext_sync_d <= ext_sync;
      ext_prev <= external_count_input;
    end
  end

  assign edge_sync = ext_sync && !ext_sync_d;
  assign edge_async = external_count_input && !ext_prev;

  always_comb
  begin
    raw_tick = 1'b0;
    if (!active)
      raw_tick = 1'b0;
    else if (ctrl[SOURCE_BIT])
      raw_tick = ctrl[SYNC_BIT] ? edge_sync : edge_async;
    else if (ctrl[GATE_BIT])
      raw_tick = gate_in;
    else
      raw_tick = 1'b1;
  end

  sat16_presc #(
    .CNT_W(8)
  ) u_presc (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clear(!timer_on || direct_wr || apply_wr),
    .tick_in(raw_tick),
    .prescale_select(ctrl[PRESCALE_LSB+1:PRESCALE_LSB]),
    .tick_out(tick)
  );

  assign blocked = pending && ctrl[WR_BLOCK_BIT];
  assign direct_wr = cnt_wr && !async_mode;
  assign start_wr = cnt_wr && async_mode && !blocked;
  assign apply_wr = pending && pend_cnt == 2'h1;

  // Async writes land late so a slow count clock cannot tear them
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pending <= 1'b0;
      pend_cnt <= 2'h0;
      pend_val <= COUNT_RESET;
    end
    else if (start_wr)
    begin
      pending <= 1'b1;
      pend_cnt <= ASYNC_WR_CYCLES;
      pend_val <= next_cnt_wr;
    end
    else if (apply_wr)
    begin
      pending <= 1'b0;
      pend_cnt <= 2'h0;
    end
    else if (pending)
      pend_cnt <= pend_cnt - 2'h1;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      ctrl <= CTRL_RESET;
    else if (ctrl_wr)
      ctrl <= sat16_alias(kind, ctrl, wr_data[15:0]) & CTRL_WR_MASK;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      period <= PERIOD_RESET;
    else if (per_wr)
      period <= sat16_alias(kind, period, wr_data[15:0]);
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      count <= COUNT_RESET;
    else if (direct_wr)
      count <= next_cnt_wr;
    else if (apply_wr)
      count <= pend_val;
    else if (tick)
      count <= (count == period) ? 16'h0000 : count + 16'h0001;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      timer_event <= 1'b0;
    else
      timer_event <= tick && !direct_wr && !apply_wr && count == period;
  end

  // Pending only shows in asynchronous mode
  assign ctrl_view = {ctrl[15:12], pending && async_mode, ctrl[10:0]};

  // Aliases are write-only and read as zero
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      rd_data <= 32'h0000_0000;
    else if (rd_en && addr_ok && kind == SAT16_WR_PLAIN)
    begin
      if (base == CTRL_OFS)
        rd_data <= {16'h0000, ctrl_view};
      else if (base == COUNT_OFS)
        rd_data <= {16'h0000, count};
      else if (base == PERIOD_OFS)
        rd_data <= {16'h0000, period};
      else
        rd_data <= 32'h0000_0000;
    end
    else
      rd_data <= 32'h0000_0000;
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  sequence async_wr_start_s;
    start_wr ##1 !start_wr;
  endsequence

  // A restart on the landing edge keeps pending up one more time
  sequence pending_done_s;
    pending [*2] ##1 (!pending || $past(start_wr));
  endsequence

  reset_values_a: assert property ($rose(rst_n) |->
    ctrl == 16'h0000 && count == 16'h0000 && period == 16'hffff)
    else $error("register reset values wrong");

  count_step_a: assert property (tick && !direct_wr && !apply_wr && count != period
    |=> count == $past(count) + 16'h0001)
    else $error("count did not step by one on a tick");

  wrap_event_a: assert property (tick && !direct_wr && !apply_wr && count == period
    |=> count == 16'h0000 && timer_event)
    else $error("count did not wrap with an event at period");

  async_pending_a: assert property (async_wr_start_s |-> pending_done_s)
    else $error("async write pending time wrong");

  write_block_a: assert property (blocked && cnt_wr
    |=> pend_val == $past(pend_val))
    else $error("blocked count write was taken");

  pending_read_a: assert property (rd_en && addr == ADDR_W'(CTRL_OFS)
    |=> rd_data[PENDING_BIT] == $past(pending && async_mode))
    else $error("pending bit read wrong");

  period_clr_a: assert property (wr_en && addr == ADDR_W'(PERIOD_OFS + 16'h0004)
    |=> period == ($past(period) & ~$past(wr_data[15:0])))
    else $error("period clear alias wrong");

  period_inv_a: assert property (wr_en && addr == ADDR_W'(PERIOD_OFS + 16'h000c)
    |=> period == ($past(period) ^ $past(wr_data[15:0])))
    else $error("period invert alias wrong");

  gate_hold_a: assert property (active && !ctrl[SOURCE_BIT] && ctrl[GATE_BIT]
    |-> raw_tick == gate_in)
    else $error("gated count ignored the gate");

  ext_source_a: assert property (active && ctrl[SOURCE_BIT] && ctrl[SYNC_BIT]
    |-> raw_tick == edge_sync)
    else $error("external sync source not counted");

  sleep_async_a: assert property (timer_on && cpu_sleep && async_mode
    && !(cpu_idle && ctrl[IDLE_STOP_BIT]) && edge_async |-> raw_tick)
    else $error("async timer stopped in sleep");

  internal_src_a: assert property (active && !ctrl[SOURCE_BIT] && !ctrl[GATE_BIT]
    |-> raw_tick)
    else $error("internal clock not counted");

endmodule

// ### tb_sat16_timer.sv
`timescale 1ns/10ps
module tb_sat16_timer
  import sat16_pkg::*;
;
  localparam logic [15:0] c_on = 16'h1 << ON_BIT;
  localparam logic [15:0] c_idl = 16'h1 << IDLE_STOP_BIT;
  localparam logic [15:0] c_blk = 16'h1 << WR_BLOCK_BIT;
  localparam logic [15:0] c_pnd = 16'h1 << PENDING_BIT;
  localparam logic [15:0] c_gat = 16'h1 << GATE_BIT;
  localparam logic [15:0] c_syn = 16'h1 << SYNC_BIT;
  localparam logic [15:0] c_src = 16'h1 << SOURCE_BIT;
  logic ref_clk = 1'b0;
  logic nrst, wr_en, rd_en, gate_in, cpu_idle, cpu_sleep, ext_pin, ext_run, timer_event;
  logic [15:0] addr, last_rd, r, m;
  logic [31:0] wr_data, rd_data, exp_v;
  logic [7:0] ext_half;
  logic [33:0] note;
  logic [33:0] notes[$];
  int error_cnt = 0;
  int comparisons = 0;
  int ev_cnt = 0;
  int e0;
  int dv[4] = '{1, 8, 64, 256};

  sat16_timer sat16_timer_i (.ref_clk(ref_clk), .nrst(nrst), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .external_count_input(ext_pin),
    .gate_in(gate_in), .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep), .timer_event(timer_event));
  sat16_ext_osc sat16_ext_osc_i (.ref_clk(ref_clk), .run(ext_run), .half_cyc(ext_half),
    .ext_clk(ext_pin));

  initial
    forever #2 ref_clk = ~ref_clk;

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic bus(logic w, logic rr, logic [15:0] a, logic [15:0] d);
    @(posedge ref_clk);
    wr_en <= w;
    rd_en <= rr;
    addr <= a;
    wr_data <= {16'h0000, d};
  endtask

  task automatic idle(int n);
    repeat (n)
    begin
      @(posedge ref_clk);
      wr_en <= 1'b0;
      rd_en <= 1'b0;
    end
  endtask

  task automatic wr(logic [15:0] a, logic [15:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask

  // Mode bits: 1 = only record, 0 = relative to previous read
  task automatic rd(logic [15:0] a, logic [15:0] e, logic [1:0] md);
    bus(1'b0, 1'b1, a, 16'h0000);
    notes.push_back({md, 16'h0000, e});
  endtask

  // Any k*div consecutive raw ticks hold exactly k passed ticks
  task automatic gap(int k, logic [15:0] dlt);
    rd(COUNT_OFS, 16'h0000, 2'b10);
    idle(k - 1);
    rd(COUNT_OFS, dlt, 2'b01);
  endtask

  // Off first so the prescaler starts clean
  task automatic mode(logic [15:0] v, int n);
    wr(CTRL_OFS, 16'h0000);
    wr(CTRL_OFS, v);
    idle(n);
  endtask

  initial
    forever
    begin
      @(posedge ref_clk);
      if (rd_en === 1'b1)
      begin
        @(negedge ref_clk);
        note = notes.pop_front();
        exp_v = note[32] ? {16'h0000, last_rd + note[15:0]} : note[31:0];
        if (!note[33])
          check("rd_data", rd_data, exp_v);
        last_rd = rd_data[15:0];
      end
    end

  always @(posedge ref_clk)
    if (timer_event === 1'b1)
      ev_cnt <= ev_cnt + 1;

  initial
  begin
    #(4 * 20000);
    error_cnt++;
    finish_test();
  end

  initial
  begin
    {nrst, wr_en, rd_en, gate_in, cpu_idle, cpu_sleep, ext_run} = 7'h00;
    addr = 16'h0000;
    wr_data = 32'h0;
    ext_half = 8'h03;
    void'($urandom(13));
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    idle(4);
    rd(CTRL_OFS, CTRL_RESET, 2'b00);
    rd(COUNT_OFS, COUNT_RESET, 2'b00);
    rd(PERIOD_OFS, PERIOD_RESET, 2'b00);
    rd(16'h0630, 16'h0000, 2'b00);
    rd(PERIOD_OFS | 16'h0004, 16'h0000, 2'b00);
    r = 16'($urandom);
    m = 16'($urandom);
    wr(PERIOD_OFS, r);
    wr(PERIOD_OFS | {12'h000, ALIAS_SET_OFS}, m);
    rd(PERIOD_OFS, r | m, 2'b00);
    wr(PERIOD_OFS | {12'h000, ALIAS_CLR_OFS}, m);
    rd(PERIOD_OFS, r & ~m, 2'b00);
    wr(PERIOD_OFS | {12'h000, ALIAS_INV_OFS}, m);
    rd(PERIOD_OFS, (r & ~m) ^ m, 2'b00);
    wr(CTRL_OFS | {12'h000, ALIAS_SET_OFS}, 16'hffff);
    rd(CTRL_OFS, CTRL_WR_MASK, 2'b00);
    wr(PERIOD_OFS, 16'hffff);
    for (int c = 0; c < 4; c++)
    begin
      mode(c_on | 16'(c << PRESCALE_LSB), 4);
      gap(3 * dv[c], 16'h0003);
    end
    mode(c_on | c_gat, 4);
    gap(16, 16'h0000);
    gate_in <= 1'b1;
    idle(4);
    gap(16, 16'h0010);
    cpu_idle <= 1'b1;
    mode(c_on, 4);
    gap(16, 16'h0010);
    mode(c_on | c_idl, 4);
    gap(16, 16'h0000);
    cpu_idle <= 1'b0;
    cpu_sleep <= 1'b1;
    mode(c_on, 4);
    gap(16, 16'h0000);
    cpu_sleep <= 1'b0;
    gate_in <= 1'b0;
    ext_run <= 1'b1;
    mode(c_on | c_src | c_syn | c_gat, 8);
    gap(24, 16'h0004);
    ext_half <= 8'h05;
    cpu_sleep <= 1'b1;
    mode(c_on | c_src, 12);
    gap(40, 16'h0004);
    cpu_sleep <= 1'b0;
    ext_run <= 1'b0;
    mode(c_on | c_src | c_blk, 4);
    wr(COUNT_OFS, 16'h0005);
    rd(CTRL_OFS, c_on | c_src | c_blk | c_pnd, 2'b00);
    wr(COUNT_OFS, 16'h0009);
    idle(2);
    rd(COUNT_OFS, 16'h0005, 2'b00);
    mode(c_on | c_src, 4);
    wr(COUNT_OFS, 16'h0005);
    wr(COUNT_OFS, 16'h0009);
    idle(3);
    rd(COUNT_OFS, 16'h0009, 2'b00);
    wr(PERIOD_OFS, 16'h0003);
    wr(COUNT_OFS, 16'h0000);
    mode(c_on, 6);
    e0 = ev_cnt;
    idle(20);
    check("events", 32'(ev_cnt - e0), 32'd5);
    idle(2);
    finish_test();
  end
endmodule
